// ---- rtl/sfxg_gate.v ----
// Exception gating for the vector floating-point unit
`timescale 1ns/1ps
`include "sfxg_regs.vh"
module sfxg_gate #(
  parameter NCOND = `SFXG_NCOND,
  parameter DW    = 32
) (
  input  wire             core_clk,
  input  wire             reset_n,
  input  wire [3:0]       reg_addr,
  input  wire [DW-1:0]    reg_wdata,
  input  wire             reg_wr,
  input  wire             reg_rd,
  output reg  [DW-1:0]    reg_rdata,
  input  wire             instr_valid,
  input  wire [2:0]       instr_class,
  input  wire [NCOND-1:0] cond_raw,
  input  wire             hw_task_switch,
  input  wire             clear_task_switched_instr,
  input  wire             ignore_numeric_error_pin,
  output reg              instr_done,
  output reg  [1:0]       fault_code,
  output reg              result_substitute,
  output reg              state_xfer_vector,
  output reg              state_xfer_legacy,
  output reg              irq
);

  reg  [`SFXG_CR_W-1:0]  cr_reg;
  reg  [`SFXG_CSR_W-1:0] csr_reg;
  reg  [`SFXG_NEV-1:0]   ist_reg;
  reg  [`SFXG_NEV-1:0]   ien_reg;
  reg  [1:0]             last_fault_reg;
  reg  [NCOND-1:0]       unmasked;
  wire                   em_flag;
  wire                   ts_flag;
  wire                   osx_flag;
  wire                   is_fp;
  wire                   is_vec;
  wire [NCOND-1:0]       cond_det;
  wire                   any_unmasked;
  wire                   any_masked;
  reg  [1:0]             fault_next;
  wire [`SFXG_NEV-1:0]   ev_set;
  wire                   wr_cr;
  wire                   wr_csr;

  assign em_flag  = cr_reg[`SFXG_CR_EM_BIT];
  assign ts_flag  = cr_reg[`SFXG_CR_TS_BIT];
  assign osx_flag = cr_reg[`SFXG_CR_OSX_BIT];
  assign is_fp    = instr_class == `SFXG_OP_FP;
  // Checksum/popcount class is not a vector op: no gating at all
  assign is_vec   = instr_class != `SFXG_OP_GPR;
  // Numeric detection only on float ops, never packed integer
  assign cond_det = (instr_valid && is_fp) ? cond_raw
                                           : {NCOND{1'b0}};

  // Per-condition mask gating, one bit each
  genvar g;
  generate
    for (g = 0; g < NCOND; g = g + 1) begin : g_mask
      always @* begin
        unmasked[g] = cond_det[g] &
                      ~csr_reg[`SFXG_CSR_MASK_LSB + g];
      end
    end
  endgenerate

  assign any_unmasked = |unmasked;
  assign any_masked   = (|cond_det) & ~any_unmasked;

  // Fault priority: emulation, then task-switched, then numeric.
  // Legacy error flag and ignore pin are deliberately not read here.
  always @* begin
    fault_next = `SFXG_F_NONE;
    if (instr_valid && is_vec) begin
      if (em_flag)
        fault_next = `SFXG_F_UD;
      else if (ts_flag)
        fault_next = `SFXG_F_NM;
      else if (any_unmasked && !osx_flag)
        fault_next = `SFXG_F_UD;
      else if (any_unmasked)
        fault_next = `SFXG_F_VFP;
    end
  end

  assign ev_set[`SFXG_EV_VFP] = fault_next == `SFXG_F_VFP;
  assign ev_set[`SFXG_EV_UD]  = fault_next == `SFXG_F_UD;
  assign ev_set[`SFXG_EV_NM]  = fault_next == `SFXG_F_NM;
  assign ev_set[`SFXG_EV_SUB] = fault_next == `SFXG_F_NONE && any_masked;

  assign wr_cr  = reg_wr && reg_addr == `SFXG_A_CR;
  assign wr_csr = reg_wr && reg_addr == `SFXG_A_CSR;

  // Control register; hardware task switch wins over a software write
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cr_reg <= `SFXG_CR_RESET;
    end else begin
      if (wr_cr)
        cr_reg <= reg_wdata[`SFXG_CR_W-1:0];
      if (clear_task_switched_instr)
        cr_reg[`SFXG_CR_TS_BIT] <= 1'b0;
      if (hw_task_switch)
        cr_reg[`SFXG_CR_TS_BIT] <= 1'b1;
    end
  end

  // Control/status: masks reset to zero, sticky flags accumulate
  always @(posedge core_clk) begin
    if (!reset_n) begin
      csr_reg <= `SFXG_CSR_RESET;
    end else if (wr_csr) begin
      csr_reg <= reg_wdata[`SFXG_CSR_W-1:0];
    end else if (instr_valid && is_fp && !em_flag && !ts_flag) begin
      csr_reg[`SFXG_CSR_FLAG_LSB+NCOND-1:`SFXG_CSR_FLAG_LSB] <=
        csr_reg[`SFXG_CSR_FLAG_LSB+NCOND-1:`SFXG_CSR_FLAG_LSB] | cond_det;
    end
  end

  // Interrupt status: set beats a same-cycle clear
  always @(posedge core_clk) begin
    if (!reset_n) begin
      ist_reg <= {`SFXG_NEV{1'b0}};
      ien_reg <= {`SFXG_NEV{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `SFXG_A_IRQ_EN)
        ien_reg <= reg_wdata[`SFXG_NEV-1:0];
      if (reg_wr && reg_addr == `SFXG_A_IRQ_CLR)
        ist_reg <= (ist_reg & ~reg_wdata[`SFXG_NEV-1:0]) | ev_set;
      else
        ist_reg <= ist_reg | ev_set;
    end
  end

  // Per-instruction outcome, registered one cycle after issue
  always @(posedge core_clk) begin
    if (!reset_n) begin
      instr_done        <= 1'b0;
      fault_code        <= `SFXG_F_NONE;
      result_substitute <= 1'b0;
      state_xfer_vector <= 1'b0;
      state_xfer_legacy <= 1'b0;
      last_fault_reg    <= `SFXG_F_NONE;
      irq               <= 1'b0;
    end else begin
      instr_done        <= instr_valid;
      fault_code        <= fault_next;
      // Masked-only conditions write default result, no handler
      result_substitute <= ev_set[`SFXG_EV_SUB];
      // Save/restore moves data regs plus control/status
      state_xfer_vector <= instr_valid && fault_next == `SFXG_F_NONE &&
                           (instr_class == `SFXG_OP_SAVE ||
                            instr_class == `SFXG_OP_RESTORE);
      // Full save also carries legacy stack and packed-int state
      state_xfer_legacy <= instr_valid && fault_next == `SFXG_F_NONE &&
                           (instr_class == `SFXG_OP_SAVE ||
                            instr_class == `SFXG_OP_RESTORE);
      if (fault_next != `SFXG_F_NONE)
        last_fault_reg <= fault_next;
      irq <= |(ist_reg & ien_reg);
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= {DW{1'b0}};
    end else if (reg_rd) begin
      case (reg_addr)
        `SFXG_A_CR:       reg_rdata <= {{(DW-`SFXG_CR_W){1'b0}}, cr_reg};
        `SFXG_A_CSR:      reg_rdata <= csr_reg;
        `SFXG_A_IRQ_STAT: reg_rdata <= {{(DW-`SFXG_NEV){1'b0}}, ist_reg};
        `SFXG_A_IRQ_EN:   reg_rdata <= {{(DW-`SFXG_NEV){1'b0}}, ien_reg};
        `SFXG_A_FAULT:    reg_rdata <= {{(DW-2){1'b0}}, last_fault_reg};
        default:          reg_rdata <= {DW{1'b0}};
      endcase
    end else begin
      reg_rdata <= {DW{1'b0}};
    end
  end

endmodule // sfxg_gate

// ---- rtl/sfxg_regs.vh ----
// Constants for the vector floating-point exception gating block
`ifndef SFXG_REGS_VH
`define SFXG_REGS_VH
// Control register bit positions
`define SFXG_CR_EM_BIT      2
`define SFXG_CR_TS_BIT      3
`define SFXG_CR_NE_BIT      5
`define SFXG_CR_OSX_BIT     10
`define SFXG_CR_W           16
`define SFXG_CR_RESET       16'h0000
// Control/status register layout
`define SFXG_CSR_W          32
`define SFXG_CSR_FLAG_LSB   0
`define SFXG_CSR_MASK_LSB   7
`define SFXG_CSR_MASK_MSB   12
`define SFXG_CSR_RESET      32'h0000_0000
`define SFXG_NCOND          6
// Register port offsets
`define SFXG_A_CR           4'h0
`define SFXG_A_CSR          4'h1
`define SFXG_A_IRQ_STAT     4'h2
`define SFXG_A_IRQ_CLR      4'h3
`define SFXG_A_IRQ_EN       4'h4
`define SFXG_A_FAULT        4'h5
// Interrupt event bits
`define SFXG_EV_VFP         0
`define SFXG_EV_UD          1
`define SFXG_EV_NM          2
`define SFXG_EV_SUB         3
`define SFXG_NEV            4
// Fault codes
`define SFXG_F_NONE         2'h0
`define SFXG_F_VFP          2'h1
`define SFXG_F_UD           2'h2
`define SFXG_F_NM           2'h3
// Instruction classes
`define SFXG_OP_FP          3'h0
`define SFXG_OP_PINT        3'h1
`define SFXG_OP_SAVE        3'h2
`define SFXG_OP_RESTORE     3'h3
`define SFXG_OP_GPR         3'h4
`endif

// ---- verification/sfxg_gate_props.sv ----
// Port checker for the vector fault gating block
`timescale 1ns/1ps
`include "sfxg_regs.vh"
module sfxg_gate_props #(
  parameter NCOND = 6,
  parameter DW    = 32
) (
  input wire             core_clk,
  input wire             reset_n,
  input wire             reg_rd,
  input wire [DW-1:0]    reg_rdata,
  input wire             instr_valid,
  input wire [2:0]       instr_class,
  input wire [NCOND-1:0] cond_raw,
  input wire             instr_done,
  input wire [1:0]       fault_code,
  input wire             result_substitute,
  input wire             state_xfer_vector,
  input wire             state_xfer_legacy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // A save issued and not faulted
  sequence save_ok_s;
    instr_valid && instr_class == `SFXG_OP_SAVE ##1 fault_code == 2'h0;
  endsequence
  issue_done_a: assert property (instr_valid |=> instr_done)
    else $error("done pulse missing");
  idle_quiet_a: assert property (!instr_valid |=> !instr_done
    && fault_code == 2'h0 && !result_substitute) else $error("idle output");
  pint_nonum_a: assert property (
    instr_valid && instr_class == `SFXG_OP_PINT |=> !result_substitute
    && fault_code != `SFXG_F_VFP) else $error("numeric on packed int");
  fp_clean_a: assert property (
    instr_valid && instr_class == 3'h0 && cond_raw == 0 |=>
    !result_substitute && fault_code != 2'h1) else $error("false condition");
  subst_nofault_a: assert property (
    result_substitute |-> fault_code == 2'h0) else $error("subst faulted");
  gpr_nofault_a: assert property (
    instr_valid && instr_class == `SFXG_OP_GPR |=> fault_code == 2'h0
    && !state_xfer_vector) else $error("gpr op touched vector");
  save_both_a: assert property (save_ok_s |-> state_xfer_vector
    && state_xfer_legacy) else $error("save moved partial state");
  rd_idle_zero_a: assert property (!reg_rd |=> reg_rdata == 0)
    else $error("read data outside slot");
endmodule // sfxg_gate_props

bind sfxg_gate sfxg_gate_props #(.NCOND(NCOND), .DW(DW)) sfxg_gate_props_i (
  .core_clk(core_clk), .reset_n(reset_n), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .instr_valid(instr_valid),
  .instr_class(instr_class), .cond_raw(cond_raw), .instr_done(instr_done),
  .fault_code(fault_code), .result_substitute(result_substitute),
  .state_xfer_vector(state_xfer_vector),
  .state_xfer_legacy(state_xfer_legacy));

// ---- verification/sfxg_os_model.sv ----
// Operating system model: not-available handler
`timescale 1ns/1ps
module sfxg_os_model (
  input wire       core_clk,
  input wire       reset_n,
  input wire [1:0] fault_code,
  output reg       clear_task_switched_instr
);
  // Handler clears the flag the cycle after a not-available fault; one-cycle pulse
  always @(posedge core_clk) begin
    clear_task_switched_instr <= reset_n && fault_code == 2'h3;
  end
endmodule // sfxg_os_model

// ---- verification/test_simd_fp_exception_gating.sv ----
// Self-checking bench for the vector fault gating block
`timescale 1ns/1ps
module test_simd_fp_exception_gating;
  reg         core_clk = 0;
  reg         reset_n = 0;
  reg  [3:0]  reg_addr = 0;
  reg  [31:0] reg_wdata = 0;
  reg         reg_wr = 0;
  reg         reg_rd = 0;
  reg         instr_valid = 0;
  reg  [2:0]  instr_class = 0;
  reg  [5:0]  cond_raw = 0;
  reg         hw_task_switch = 0;
  reg         ignore_numeric_error_pin = 0;
  wire [31:0] reg_rdata;
  wire [1:0]  fault_code;
  wire        instr_done, result_substitute, xv, xl, irq, clr;
  integer     errors = 0, n_tests = 0, cyc = 0, i;
  always #50 core_clk = ~core_clk;
  sfxg_gate sfxg_gate_i (.core_clk(core_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .instr_valid(instr_valid),
    .instr_class(instr_class), .cond_raw(cond_raw),
    .hw_task_switch(hw_task_switch), .clear_task_switched_instr(clr),
    .ignore_numeric_error_pin(ignore_numeric_error_pin),
    .instr_done(instr_done), .fault_code(fault_code),
    .result_substitute(result_substitute), .state_xfer_vector(xv),
    .state_xfer_legacy(xl), .irq(irq));
  sfxg_os_model sfxg_os_model_i (.core_clk(core_clk), .reset_n(reset_n),
    .fault_code(fault_code), .clear_task_switched_instr(clr));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] a, input [31:0] d);
    @(posedge core_clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk); reg_wr <= 0;
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge core_clk); reg_rd <= 1; reg_addr <= a;
    @(posedge core_clk); reg_rd <= 0;
    @(negedge core_clk); chk(reg_rdata, e);
  endtask
  // Issue one instruction, check the answer slot
  task ins(input [2:0] c, input [5:0] cd, input [1:0] f, input s);
    reg x;
    x = (c == 3'h2 || c == 3'h3) && f == 2'h0;
    @(posedge core_clk); instr_valid <= 1; instr_class <= c; cond_raw <= cd;
    @(posedge core_clk); instr_valid <= 0;
    @(negedge core_clk);
    chk({instr_done, fault_code, result_substitute, xv, xl}, {1'b1, f, s, x, x});
  endtask
  // Irq is two cycles behind its cause
  task irqchk(input e);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk); chk(irq, e);
  endtask
  task end_of_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard; the sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1;
    rd(4'h0, 0); rd(4'h1, 0); rd(4'hf, 0);
    ins(3'h0, 6'h01, 2'h2, 0);
    wr(4'h0, 32'h420);
    ignore_numeric_error_pin <= 1;
    for (i = 0; i < 6; i++) ins(3'h0, 6'h1 << i, 2'h1, 0);
    for (i = 0; i < 6; i++) begin
      wr(4'h1, 32'h80 << i); rd(4'h1, 32'h80 << i);
      ins(3'h0, 6'h1 << i, 2'h0, 1);
      ins(3'h0, (6'h1 << i) | (6'h1 << ((i + 1) % 6)), 2'h1, 0);
    end
    ins(3'h0, 6'h0, 2'h0, 0);
    ins(3'h1, 6'h3f, 2'h0, 0);
    ins(3'h2, 6'h0, 2'h0, 0); ins(3'h3, 6'h0, 2'h0, 0);
    wr(4'h0, 32'h40c); ins(3'h0, 6'h1, 2'h2, 0);
    ins(3'h4, 6'h1, 2'h0, 0);
    wr(4'h0, 32'h408); ins(3'h0, 6'h1, 2'h3, 0);
    repeat (2) @(posedge core_clk);
    rd(4'h0, 32'h400);
    @(posedge core_clk); hw_task_switch <= 1;
    @(posedge core_clk); hw_task_switch <= 0;
    rd(4'h0, 32'h408); wr(4'h0, 32'h400);
    wr(4'h3, 32'hf); wr(4'h2, 32'hf); rd(4'h2, 0); wr(4'h4, 1);
    ins(3'h0, 6'h1, 2'h1, 0); irqchk(1); rd(4'h2, 1); rd(4'h5, 1);
    wr(4'h4, 0); irqchk(0); wr(4'h4, 1); irqchk(1);
    wr(4'h3, 1); irqchk(0); rd(4'h2, 0);
    end_of_test;
  end
endmodule // test_simd_fp_exception_gating
